// ===== design/stall_prevention.sv
// Notes on behaviour
// - V/f and IM: hold acceleration while current exceeds acceleration level.
// - Resume acceleration once current is 15% below acceleration level.
// - Constant power: acceleration level falls, floored at lower limit.
// - PM method: over level past qualify time, decelerate with stall time.
// - PM method: re-accelerate once current is 15% below acceleration level.
// - Acceleration enable defaults on; current level range 0 to 150%.
// - Stall deceleration time zero means use active deceleration time.
// - Deceleration protection off: follow deceleration ignoring bus voltage.
// - Deceleration protection on: hold frequency while bus voltage is high.
// - Bus threshold 330 to 410 V, default 395 V, doubled for 400 V.
// - Run protection never acts below 6 Hz output frequency.
// - Run protection only for V/f and PM methods; mode 0 to 2.
// - Run mode 0: just follow the frequency command.
// - Run mode 1: over run level, decelerate with first time set.
// - Recover after current under run level minus 2% for 100 ms.
// - Run mode 2: as mode 1 but always second deceleration time.
// - Run current level range 30 to 150 percent.
// - Analog function 7: run level is minimum of setting and input.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module stall_prevention
   import stall_pkg::*;
#(
   parameter int MS_CYC  = stall_pkg::MS_CYCLES,
   parameter int REC_CYC = stall_pkg::RECOVER_CYCLES
) (
   input  wire logic                    ref_clk,
   input  wire logic                    rst,
   input  wire logic                    clk_en,
   input  wire logic [3:0]              addr,
   input  wire logic [15:0]             wdata,
   input  wire logic                    wr,
   input  wire logic                    rd,
   output logic      [15:0]             rdata,
   input  wire logic [15:0]             freq_cmd,
   input  wire logic [15:0]             out_freq,
   input  wire logic [15:0]             base_freq,
   input  wire logic [15:0]             out_current,
   input  wire logic [15:0]             bus_voltage,
   input  wire logic [15:0]             analog_level,
   output stall_pkg::ramp_cmd_type      ramp_cmd,
   output stall_pkg::decel_sel_type     decel_select,
   output logic                         stall_active
);
   import stall_pkg::*;

   typedef struct packed {
      logic [15:0]   cur_s1;
      logic [15:0]   cur_s2;
      logic [15:0]   volt_s1;
      logic [15:0]   volt_s2;
      logic [15:0]   ana_s1;
      logic [15:0]   ana_s2;
      logic [1:0]    method;
      logic          acc_en;
      logic          dec_en;
      logic [1:0]    run_mode;
      logic          class400;
      logic [3:0]    ain_func;
      logic [15:0]   acc_lvl;
      logic [15:0]   acc_lim;
      logic [15:0]   dec_volt;
      logic [15:0]   run_lvl;
      logic [15:0]   stall_t;
      logic [15:0]   qual_t;
      state_type     state;
      logic [23:0]   ms_div;
      logic [15:0]   qual_cnt;
      logic [23:0]   rec_cnt;
      ramp_cmd_type  ramp;
      decel_sel_type dsel;
      logic          active;
      logic [15:0]   rdata;
   } all_type;

   all_type q_reg;
   all_type q_next;

   function automatic logic [15:0] clamp(input logic [15:0] v,
                                         input logic [15:0] lo,
                                         input logic [15:0] hi);
      if (v < lo) begin
         clamp = lo;
      end else if (v > hi) begin
         clamp = hi;
      end else begin
         clamp = v;
      end
   endfunction

   // True when a sits more than 15% below b
   function automatic logic below_hyst(input logic [47:0] a,
                                       input logic [47:0] b);
      below_hyst = (a * 48'(HYST_DEN)) < (b * 48'(HYST_NUM));
   endfunction

   logic        accel;
   logic        decel;
   logic        cp_range;
   logic [47:0] p_co;
   logic [47:0] p_lb;
   logic        acc_over;
   logic        acc_low;
   logic [16:0] volt_thr;
   logic        volt_over;
   logic        volt_under;
   logic [15:0] eff_run;
   logic        run_over;
   logic        run_low;
   logic        run_ok;
   logic        low_freq;
   logic        ms_tick;
   decel_sel_type stall_sel;

   always_comb begin
      accel    = freq_cmd > out_freq;
      decel    = freq_cmd < out_freq;
      cp_range = out_freq > base_freq;
      p_co     = 48'(q_reg.cur_s2) * 48'(out_freq);
      p_lb     = 48'(q_reg.acc_lvl) * 48'(base_freq);
      // Scaling by base/out keeps the level falling with speed
      if (cp_range) begin
         acc_over = (p_co > p_lb) && (q_reg.cur_s2 > q_reg.acc_lim);
         acc_low  = below_hyst(p_co, p_lb)
                 || below_hyst(48'(q_reg.cur_s2), 48'(q_reg.acc_lim));
      end else begin
         acc_over = q_reg.cur_s2 > q_reg.acc_lvl;
         acc_low  = below_hyst(48'(q_reg.cur_s2),
                               48'(q_reg.acc_lvl));
      end
      volt_thr   = q_reg.class400 ? {q_reg.dec_volt, 1'b0}
                                  : {1'b0, q_reg.dec_volt};
      volt_over  = {1'b0, q_reg.volt_s2} > volt_thr;
      volt_under = {1'b0, q_reg.volt_s2} < volt_thr;
      if (q_reg.ain_func == AIN_STALL && q_reg.ana_s2 < q_reg.run_lvl) begin
         eff_run = q_reg.ana_s2;
      end else begin
         eff_run = q_reg.run_lvl;
      end
      run_over = q_reg.cur_s2 > eff_run;
      run_low  = ({1'b0, q_reg.cur_s2} + RUN_MARGIN) < {1'b0, eff_run};
      run_ok   = (q_reg.method != METHOD_IM_OLV)
              && (q_reg.run_mode != 2'h0);
      low_freq = out_freq < LOW_FREQ;
      ms_tick  = q_reg.ms_div == 24'(MS_CYC - 1);
      stall_sel = (q_reg.stall_t == 16'h0000) ? DSEL_ACTIVE
                                              : DSEL_STALL;
   end

   always_comb begin
      q_next        = q_reg;
      q_next.cur_s1 = out_current;
      q_next.cur_s2 = q_reg.cur_s1;
      q_next.volt_s1 = bus_voltage;
      q_next.volt_s2 = q_reg.volt_s1;
      q_next.ana_s1 = analog_level;
      q_next.ana_s2 = q_reg.ana_s1;
      q_next.rdata  = 16'h0000;
      q_next.ms_div = ms_tick ? 24'h000000 : q_reg.ms_div + 24'h000001;

      // Writes are clamped into each setting's legal range; the qualify time is taken as written
      if (wr) begin
         if (addr == ADDR_CTRL) begin
            q_next.acc_en   = wdata[CTRL_ACC_EN];
            q_next.dec_en   = wdata[CTRL_DEC_EN];
            q_next.run_mode = (wdata[CTRL_MODE_LO +: 2] > RUN_MODE_MAX)
                            ? RUN_MODE_MAX : wdata[CTRL_MODE_LO +: 2];
            q_next.method   = wdata[CTRL_METHOD_LO +: 2];
            q_next.class400 = wdata[CTRL_CLASS400];
            q_next.ain_func = wdata[CTRL_AIN_LO +: 4];
         end else if (addr == ADDR_ACC_LVL) begin
            q_next.acc_lvl = clamp(wdata, 16'h0000, ACC_LVL_MAX);
         end else if (addr == ADDR_ACC_LIM) begin
            q_next.acc_lim = clamp(wdata, 16'h0000, ACC_LIM_MAX);
         end else if (addr == ADDR_DEC_VOLT) begin
            q_next.dec_volt = clamp(wdata, DEC_VOLT_MIN,
                                    DEC_VOLT_MAX);
         end else if (addr == ADDR_RUN_LVL) begin
            q_next.run_lvl = clamp(wdata, RUN_LVL_MIN,
                                   RUN_LVL_MAX);
         end else if (addr == ADDR_STALL_T) begin
            q_next.stall_t = clamp(wdata, 16'h0000, STALL_T_MAX);
         end else if (addr == ADDR_QUAL_T) begin
            q_next.qual_t = wdata;
         end
      end

      // Unmapped reads return zero
      if (rd) begin
         if (addr == ADDR_CTRL) begin
            q_next.rdata = {4'h0, q_reg.ain_func, 1'b0, q_reg.class400,
                            q_reg.method, q_reg.run_mode,
                            q_reg.dec_en, q_reg.acc_en};
         end else if (addr == ADDR_ACC_LVL) begin
            q_next.rdata = q_reg.acc_lvl;
         end else if (addr == ADDR_ACC_LIM) begin
            q_next.rdata = q_reg.acc_lim;
         end else if (addr == ADDR_DEC_VOLT) begin
            q_next.rdata = q_reg.dec_volt;
         end else if (addr == ADDR_RUN_LVL) begin
            q_next.rdata = q_reg.run_lvl;
         end else if (addr == ADDR_STALL_T) begin
            q_next.rdata = q_reg.stall_t;
         end else if (addr == ADDR_QUAL_T) begin
            q_next.rdata = q_reg.qual_t;
         end else if (addr == ADDR_STATUS) begin
            q_next.rdata = {9'h000, q_reg.state, q_reg.ramp, q_reg.dsel};
         end else if (addr == ADDR_EFF_RUN) begin
            q_next.rdata = eff_run;
         end
      end

      // Phase is judged only from idle, so one function owns the ramp
      case (q_reg.state)
         ST_IDLE: begin
            q_next.qual_cnt = 16'h0000;
            q_next.rec_cnt  = 24'h000000;
            if (accel && q_reg.acc_en && acc_over) begin
               q_next.state = (q_reg.method == METHOD_PM_OLV)
                            ? ST_ACC_QUAL : ST_ACC_HOLD;
            end else if (decel && q_reg.dec_en && volt_over) begin
               q_next.state = ST_DEC_HOLD;
            end else if (!accel && !decel && run_ok && !low_freq
                         && run_over) begin
               q_next.state = ST_RUN_DEC;
            end
         end
         ST_ACC_HOLD: begin
            if (acc_low || !accel || !q_reg.acc_en) begin
               q_next.state = ST_IDLE;
            end
         end
         ST_ACC_QUAL: begin
            if (!acc_over || !q_reg.acc_en) begin
               q_next.state = ST_IDLE;
            end else if (q_reg.qual_cnt >= q_reg.qual_t) begin
               q_next.state = ST_ACC_DEC;
            end else if (ms_tick) begin
               q_next.qual_cnt = q_reg.qual_cnt + 16'h0001;
            end
         end
         ST_ACC_DEC: begin
            if (acc_low || !q_reg.acc_en) begin
               q_next.state = ST_IDLE;
            end
         end
         ST_DEC_HOLD: begin
            if (volt_under || !q_reg.dec_en) begin
               q_next.state = ST_IDLE;
            end
         end
         ST_RUN_DEC: begin
            q_next.rec_cnt = 24'h000000;
            if (low_freq || !run_ok) begin
               q_next.state = ST_IDLE;
            end else if (run_low) begin
               q_next.state = ST_RUN_REC;
            end
         end
         ST_RUN_REC: begin
            if (low_freq || !run_ok) begin
               q_next.state = ST_IDLE;
            end else if (run_over) begin
               q_next.state = ST_RUN_DEC;
            end else if (!run_low) begin
               q_next.rec_cnt = 24'h000000;
            end else if (q_reg.rec_cnt == 24'(REC_CYC - 1)) begin
               q_next.state = ST_IDLE;
            end else begin
               q_next.rec_cnt = q_reg.rec_cnt + 24'h000001;
            end
         end
         default: begin
            q_next.state = ST_IDLE;
         end
      endcase

      q_next.ramp = RAMP_FOLLOW;
      q_next.dsel = DSEL_ACTIVE;
      case (q_next.state)
         ST_ACC_HOLD, ST_DEC_HOLD, ST_RUN_REC: begin
            q_next.ramp = RAMP_HOLD;
         end
         ST_ACC_DEC: begin
            q_next.ramp = RAMP_DECEL;
            q_next.dsel = stall_sel;
         end
         ST_RUN_DEC: begin
            q_next.ramp = RAMP_DECEL;
            q_next.dsel = (q_reg.run_mode == 2'h2)
                        ? DSEL_SECOND : DSEL_FIRST;
         end
         default: begin
            q_next.ramp = RAMP_FOLLOW;
         end
      endcase
      q_next.active = q_next.state != ST_IDLE;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         q_reg          <= '0;
         q_reg.method   <= RST_METHOD;
         q_reg.acc_en   <= RST_ACC_EN;
         q_reg.dec_en   <= RST_DEC_EN;
         q_reg.run_mode <= RST_RUN_MODE;
         q_reg.ain_func <= RST_AIN_FUNC;
         q_reg.acc_lvl  <= RST_ACC_LVL;
         q_reg.acc_lim  <= RST_ACC_LIM;
         q_reg.dec_volt <= RST_DEC_VOLT;
         q_reg.run_lvl  <= RST_RUN_LVL;
         q_reg.stall_t  <= RST_STALL_T;
         q_reg.qual_t   <= RST_QUAL_T;
         q_reg.state    <= ST_IDLE;
         q_reg.ramp     <= RAMP_FOLLOW;
         q_reg.dsel     <= DSEL_ACTIVE;
      end else if (clk_en) begin
         q_reg <= q_next;
      end
   end

   assign rdata        = q_reg.rdata;
   assign ramp_cmd     = q_reg.ramp;
   assign decel_select = q_reg.dsel;
   assign stall_active = q_reg.active;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence acc_trip_s;
      clk_en && q_reg.state == ST_IDLE && accel && q_reg.acc_en && acc_over;
   endsequence

   acc_halt_a: assert property (
      acc_trip_s ##0 (q_reg.method != METHOD_PM_OLV)
      |=> ramp_cmd == RAMP_HOLD && stall_active)
      else $error("acceleration not halted on overcurrent");

   acc_resume_a: assert property (
      clk_en && q_reg.state == ST_ACC_HOLD && acc_low
      |=> ramp_cmd == RAMP_FOLLOW && q_reg.state == ST_IDLE)
      else $error("acceleration not resumed after hysteresis");

   pm_decel_a: assert property (
      clk_en && q_reg.state == ST_ACC_QUAL && acc_over && q_reg.acc_en
      && q_reg.qual_cnt >= q_reg.qual_t
      |=> ramp_cmd == RAMP_DECEL
      && decel_select == (($past(q_reg.stall_t) == 16'h0000)
                          ? DSEL_ACTIVE : DSEL_STALL))
      else $error("PM stall deceleration not started");

   pm_resume_a: assert property (
      clk_en && q_reg.state == ST_ACC_DEC && acc_low
      |=> ramp_cmd == RAMP_FOLLOW)
      else $error("PM re-acceleration missing");

   dec_off_a: assert property (
      clk_en && !q_reg.dec_en |=> q_reg.state != ST_DEC_HOLD)
      else $error("deceleration hold while disabled");

   dec_hold_a: assert property (
      clk_en && q_reg.state == ST_IDLE && decel && q_reg.dec_en
      && volt_over && !(accel && q_reg.acc_en && acc_over)
      |=> ramp_cmd == RAMP_HOLD ##0 (q_reg.state == ST_DEC_HOLD))
      else $error("frequency not held on high bus voltage");

   low_freq_a: assert property (
      clk_en && low_freq
      |=> q_reg.state != ST_RUN_DEC && q_reg.state != ST_RUN_REC)
      else $error("run protection active below 6 Hz");

   run_method_a: assert property (
      clk_en && (q_reg.method == METHOD_IM_OLV || q_reg.run_mode == 2'h0)
      |=> q_reg.state != ST_RUN_DEC)
      else $error("run protection in a method or mode without it");

   run_sel_a: assert property (
      q_reg.state == ST_RUN_DEC && $past(clk_en)
      |-> decel_select == (($past(q_reg.run_mode) == 2'h2)
                           ? DSEL_SECOND : DSEL_FIRST))
      else $error("wrong deceleration time in run protection");

   recover_a: assert property (
      clk_en && q_reg.state == ST_RUN_REC && q_next.state == ST_IDLE
      && !low_freq && run_ok
      |-> q_reg.rec_cnt == 24'(REC_CYC - 1))
      else $error("run recovery before full qualification");

   run_level_a: assert property (
      clk_en && q_reg.state == ST_IDLE && !accel && !decel && run_ok
      && !low_freq && q_reg.ain_func == AIN_STALL
      && q_reg.cur_s2 > q_reg.ana_s2 |=> q_reg.state == ST_RUN_DEC)
      else $error("run protection ignored the analog level");

endmodule
`default_nettype wire

// ===== design/stall_pkg.sv
package stall_pkg;

   // Clock and timing
   localparam int CLK_PERIOD_NS   = 100;
   localparam int MS_TIME_NS      = 1_000_000;
   localparam int MS_CYCLES       = MS_TIME_NS / CLK_PERIOD_NS;
   localparam int RECOVER_TIME_MS = 100;
   localparam int RECOVER_CYCLES  = RECOVER_TIME_MS * MS_CYCLES;

   // Register indices on the plain port
   localparam logic [3:0] ADDR_CTRL      = 4'h0;
   localparam logic [3:0] ADDR_ACC_LVL   = 4'h1;
   localparam logic [3:0] ADDR_ACC_LIM   = 4'h2;
   localparam logic [3:0] ADDR_DEC_VOLT  = 4'h3;
   localparam logic [3:0] ADDR_RUN_LVL   = 4'h4;
   localparam logic [3:0] ADDR_STALL_T   = 4'h5;
   localparam logic [3:0] ADDR_QUAL_T    = 4'h6;
   localparam logic [3:0] ADDR_STATUS    = 4'h7;
   localparam logic [3:0] ADDR_EFF_RUN   = 4'h8;

   // Control register field positions
   localparam int CTRL_ACC_EN    = 0;
   localparam int CTRL_DEC_EN    = 1;
   localparam int CTRL_MODE_LO   = 2;
   localparam int CTRL_METHOD_LO = 4;
   localparam int CTRL_CLASS400  = 6;
   localparam int CTRL_AIN_LO    = 8;

   // Control methods
   localparam logic [1:0] METHOD_VF_OPEN   = 2'h0;
   localparam logic [1:0] METHOD_VF_CLOSED = 2'h1;
   localparam logic [1:0] METHOD_IM_OLV    = 2'h2;
   localparam logic [1:0] METHOD_PM_OLV    = 2'h3;

   // Reset values (currents in 0.1 %, volts, time in 0.1 s and ms)
   localparam logic [1:0]  RST_METHOD   = 2'h0;
   localparam logic        RST_ACC_EN   = 1'b1;
   localparam logic        RST_DEC_EN   = 1'b1;
   localparam logic [1:0]  RST_RUN_MODE = 2'h1;
   localparam logic [3:0]  RST_AIN_FUNC = 4'h0;
   localparam logic [15:0] RST_ACC_LVL  = 16'h05DC;
   localparam logic [15:0] RST_ACC_LIM  = 16'h01F4;
   localparam logic [15:0] RST_DEC_VOLT = 16'h018B;
   localparam logic [15:0] RST_RUN_LVL  = 16'h04B0;
   localparam logic [15:0] RST_STALL_T  = 16'h0000;
   localparam logic [15:0] RST_QUAL_T   = 16'h0032;

   // Setting ranges
   localparam logic [15:0] ACC_LVL_MAX  = 16'h05DC;
   localparam logic [15:0] ACC_LIM_MAX  = 16'h03E8;
   localparam logic [15:0] DEC_VOLT_MIN = 16'h014A;
   localparam logic [15:0] DEC_VOLT_MAX = 16'h019A;
   localparam logic [15:0] RUN_LVL_MIN  = 16'h012C;
   localparam logic [15:0] RUN_LVL_MAX  = 16'h05DC;
   localparam logic [15:0] STALL_T_MAX  = 16'hEA60;
   localparam logic [1:0]  RUN_MODE_MAX = 2'h2;

   // Behaviour constants
   localparam logic [15:0] LOW_FREQ     = 16'h0258;
   localparam logic [16:0] RUN_MARGIN   = 17'h00014;
   localparam logic [3:0]  AIN_STALL    = 4'h7;
   localparam logic [4:0]  HYST_DEN     = 5'h14;
   localparam logic [4:0]  HYST_NUM     = 5'h11;

   typedef enum logic [1:0] {RAMP_FOLLOW, RAMP_HOLD, RAMP_DECEL} ramp_cmd_type;
   typedef enum logic [1:0] {
      DSEL_ACTIVE, DSEL_FIRST, DSEL_SECOND, DSEL_STALL
   } decel_sel_type;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ACC_HOLD, ST_ACC_QUAL, ST_ACC_DEC,
      ST_DEC_HOLD, ST_RUN_DEC, ST_RUN_REC
   } state_type;

endpackage

// ===== sim/motor_feedback.sv
`timescale 1ns/1ps
`default_nettype none
module motor_feedback (
   input  wire logic        ref_clk,
   input  wire logic        slow,
   input  wire logic [15:0] cur_set,
   input  wire logic [15:0] volt_set,
   output logic      [15:0] out_current,
   output logic      [15:0] bus_voltage
);
   logic [15:0] cur_reg;
   logic [15:0] volt_reg;

   // Slow mode adds one sample of lag, like a filtered sensor path
   always_ff @(posedge ref_clk) begin
      cur_reg     <= cur_set;
      volt_reg    <= volt_set;
      out_current <= slow ? cur_reg : cur_set;
      bus_voltage <= slow ? volt_reg : volt_set;
   end
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import stall_pkg::*;
   localparam logic [15:0] RST_TAB [10] = '{16'h0007, 16'h05DC, 16'h01F4,
      16'h018B, 16'h04B0, 16'h0000, 16'h0032, 16'h0000, 16'h04B0, 16'h0000};
   logic          ref_clk = 1'b0;
   logic          rst = 1'b1;
   logic          clk_en = 1'b1;
   logic [3:0]    addr = 4'h0;
   logic [15:0]   wdata = 16'h0000;
   logic          wr = 1'b0;
   logic          rd = 1'b0;
   logic [15:0]   rdata;
   logic [15:0]   freq_cmd = 16'h0000;
   logic [15:0]   out_freq = 16'h0000;
   logic [15:0]   base_freq = 16'h1388;
   logic [15:0]   cur_set = 16'h0000;
   logic [15:0]   volt_set = 16'h0000;
   logic [15:0]   analog_level = 16'h0000;
   logic          slow = 1'b0;
   logic [15:0]   out_current;
   logic [15:0]   bus_voltage;
   ramp_cmd_type  ramp_cmd;
   decel_sel_type decel_select;
   logic          stall_active;
   logic [15:0]   rv;
   int            n_errors = 0;
   int            n_compared = 0;

   always #50 ref_clk = ~ref_clk;

   stall_prevention #(.MS_CYC(10), .REC_CYC(20)) i_stall_prevention (
      .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .freq_cmd(freq_cmd),
      .out_freq(out_freq), .base_freq(base_freq), .out_current(out_current),
      .bus_voltage(bus_voltage), .analog_level(analog_level),
      .ramp_cmd(ramp_cmd), .decel_select(decel_select),
      .stall_active(stall_active));

   motor_feedback i_motor_feedback (
      .ref_clk(ref_clk), .slow(slow), .cur_set(cur_set),
      .volt_set(volt_set), .out_current(out_current),
      .bus_voltage(bus_voltage));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("Compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Reset returns the settings to their reset values too, so every scenario starts idle
   task automatic restart(input logic [15:0] ctrl);
      @(posedge ref_clk);
      rst <= 1'b1;
      base_freq <= 16'h1388;
      slow <= 1'b0;
      freq_cmd <= 16'h0000;
      out_freq <= 16'h0000;
      cur_set <= 16'h0000;
      volt_set <= 16'h0000;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      bus_wr(ADDR_CTRL, ctrl);
   endtask

   task automatic drive(input logic [15:0] fc, input logic [15:0] of,
                        input logic [15:0] cur, input logic [15:0] v);
      @(posedge ref_clk);
      freq_cmd <= fc;
      out_freq <= of;
      cur_set <= cur;
      volt_set <= v;
   endtask

   task automatic wait_out(input ramp_cmd_type c, input decel_sel_type s,
                           input bit sel);
      for (int i = 0; i < 60; i++) begin
         if (ramp_cmd === c && (!sel || decel_select === s)) break;
         @(posedge ref_clk);
         #1;
      end
      check({14'h0000, ramp_cmd}, {14'h0000, c});
      if (sel) check({14'h0000, decel_select}, {14'h0000, s});
   endtask

   task automatic hold_out(input ramp_cmd_type c, input int n);
      repeat (n) begin
         @(posedge ref_clk);
         #1;
         check({14'h0000, ramp_cmd}, {14'h0000, c});
      end
   endtask

   task automatic s_regs();
      restart(16'h0007);
      for (int a = 0; a < 10; a++) begin
         bus_rd(a[3:0], rv);
         check(rv, RST_TAB[a]);
      end
      bus_wr(ADDR_RUN_LVL, 16'h0064);
      bus_rd(ADDR_RUN_LVL, rv);
      check(rv, 16'h012C);
      bus_wr(ADDR_DEC_VOLT, 16'h01F4);
      bus_rd(ADDR_DEC_VOLT, rv);
      check(rv, 16'h019A);
      bus_wr(ADDR_CTRL, 16'h000F);
      bus_rd(ADDR_CTRL, rv);
      check(rv, 16'h000B);
      @(posedge ref_clk);
      clk_en <= 1'b0;
      bus_wr(ADDR_ACC_LVL, 16'h0010);
      clk_en <= 1'b1;
      bus_rd(ADDR_ACC_LVL, rv);
      check(rv, 16'h05DC);
   endtask

   task automatic s_accel();
      restart(16'h0027);
      drive(16'h0BB8, 16'h03E8, 16'h0640, 16'h012C);
      wait_out(RAMP_HOLD, DSEL_ACTIVE, 1'b1);
      check({15'h0000, stall_active}, 16'h0001);
      drive(16'h0BB8, 16'h03E8, 16'h04FB, 16'h012C);
      hold_out(RAMP_HOLD, 8);
      drive(16'h0BB8, 16'h03E8, 16'h04FA, 16'h012C);
      wait_out(RAMP_FOLLOW, DSEL_ACTIVE, 1'b1);
      check({15'h0000, stall_active}, 16'h0000);
      restart(16'h0026);
      drive(16'h0BB8, 16'h03E8, 16'h0640, 16'h012C);
      hold_out(RAMP_FOLLOW, 8);
      // Constant power: 4x base floors at the lower limit, 2x gives 75%
      restart(16'h0027);
      base_freq <= 16'h03E8;
      drive(16'h1388, 16'h0FA0, 16'h01E0, 16'h012C);
      hold_out(RAMP_FOLLOW, 8);
      drive(16'h1388, 16'h07D0, 16'h0320, 16'h012C);
      wait_out(RAMP_HOLD, DSEL_ACTIVE, 1'b1);
   endtask

   task automatic s_decel();
      restart(16'h0007);
      drive(16'h03E8, 16'h0BB8, 16'h0640, 16'h012C);
      hold_out(RAMP_FOLLOW, 8);
      drive(16'h03E8, 16'h0BB8, 16'h0640, 16'h0190);
      wait_out(RAMP_HOLD, DSEL_ACTIVE, 1'b1);
      drive(16'h03E8, 16'h0BB8, 16'h0640, 16'h018B);
      hold_out(RAMP_HOLD, 6);
      drive(16'h03E8, 16'h0BB8, 16'h0640, 16'h0186);
      wait_out(RAMP_FOLLOW, DSEL_ACTIVE, 1'b1);
      drive(16'h03E8, 16'h0BB8, 16'h0640, 16'h0190);
      wait_out(RAMP_HOLD, DSEL_ACTIVE, 1'b1);
      restart(16'h0005);
      drive(16'h03E8, 16'h0BB8, 16'h0000, 16'h0190);
      hold_out(RAMP_FOLLOW, 8);
      restart(16'h0047);
      drive(16'h03E8, 16'h0BB8, 16'h0000, 16'h01F4);
      hold_out(RAMP_FOLLOW, 8);
      drive(16'h03E8, 16'h0BB8, 16'h0000, 16'h0320);
      wait_out(RAMP_HOLD, DSEL_ACTIVE, 1'b1);
   endtask

   // Run table: mode, method, output frequency, expected selection
   task automatic s_run(input logic [1:0] mode, input logic [1:0] meth,
                        input logic [15:0] of, input decel_sel_type s);
      restart({10'h000, meth, mode, 2'h3});
      drive(of, of, 16'h0514, 16'h012C);
      if (s == DSEL_ACTIVE) begin
         hold_out(RAMP_FOLLOW, 10);
      end else begin
         wait_out(RAMP_DECEL, s, 1'b1);
         drive(of, of, 16'h049C, 16'h012C);
         hold_out(RAMP_DECEL, 6);
         drive(of, of, 16'h049B, 16'h012C);
         wait_out(RAMP_HOLD, s, 1'b0);
         hold_out(RAMP_HOLD, 19);
         hold_out(RAMP_FOLLOW, 1);
      end
   endtask

   task automatic s_analog();
      restart(16'h0707);
      analog_level <= 16'h03E8;
      repeat (4) @(posedge ref_clk);
      bus_rd(ADDR_EFF_RUN, rv);
      check(rv, 16'h03E8);
      drive(16'h1388, 16'h1388, 16'h044C, 16'h012C);
      wait_out(RAMP_DECEL, DSEL_FIRST, 1'b1);
      @(posedge ref_clk);
      analog_level <= 16'h0514;
      repeat (4) @(posedge ref_clk);
      bus_rd(ADDR_EFF_RUN, rv);
      check(rv, 16'h04B0);
   endtask

   task automatic s_pm(input logic [15:0] st, input decel_sel_type s);
      restart(16'h0037);
      slow <= 1'b1;
      bus_wr(ADDR_QUAL_T, 16'h0003);
      bus_wr(ADDR_STALL_T, st);
      drive(16'h0BB8, 16'h03E8, 16'h0640, 16'h012C);
      hold_out(RAMP_FOLLOW, 15);
      check({15'h0000, stall_active}, 16'h0001);
      wait_out(RAMP_DECEL, s, 1'b1);
      drive(16'h0BB8, 16'h03E8, 16'h04FA, 16'h012C);
      wait_out(RAMP_FOLLOW, DSEL_ACTIVE, 1'b0);
   endtask

   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      s_regs();
      s_accel();
      s_decel();
      s_run(2'h1, METHOD_VF_OPEN, 16'h1388, DSEL_FIRST);
      s_run(2'h2, METHOD_VF_CLOSED, 16'h1388, DSEL_SECOND);
      s_run(2'h1, METHOD_PM_OLV, 16'h1388, DSEL_FIRST);
      s_run(2'h0, METHOD_VF_OPEN, 16'h1388, DSEL_ACTIVE);
      s_run(2'h1, METHOD_IM_OLV, 16'h1388, DSEL_ACTIVE);
      s_run(2'h1, METHOD_VF_OPEN, 16'h0257, DSEL_ACTIVE);
      s_analog();
      s_pm(16'h0064, DSEL_STALL);
      s_pm(16'h0000, DSEL_ACTIVE);
      final_report();
   end

   // Whole run is several hundred cycles; this only cuts a hang short
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      final_report();
   end
endmodule
`default_nettype wire
